/* plm_consts.vh */
`ifndef PLM_CONSTS_VH
`define PLM_CONSTS_VH

// register byte addresses
`define PLM_ADDR_HCC_SET 12'h050
`define PLM_ADDR_HCC_CLR 12'h054
`define PLM_ADDR_PWR_CTRL 12'h060
`define PLM_ADDR_STATUS 12'h064

// field positions
`define PLM_HCC_LPS_BIT 19
`define PLM_CTRL_DSTATE_LO 0
`define PLM_CTRL_PORT_IE_BIT 2

// reset values
`define PLM_HCC_RST 32'h0000_0000
`define PLM_CTRL_RST 3'h0

// host power state codes
`define PLM_DSTATE_D2 2'h2

// axi responses
`define PLM_RESP_OKAY 2'h0
`define PLM_RESP_SLVERR 2'h2

// timing: clock period and documented limits
`define PLM_CLK_PERIOD_NS 8
`define PLM_WAKE_MAX_NS 2000000
`define PLM_WAKE_MAX_CYC (`PLM_WAKE_MAX_NS / `PLM_CLK_PERIOD_NS)
`define PLM_SETTLE_NS 10000
`define PLM_SETTLE_CYC ((`PLM_SETTLE_NS + `PLM_CLK_PERIOD_NS - 1) / `PLM_CLK_PERIOD_NS)

// event codes reported to the link
`define PLM_EVT_NONE 2'h0
`define PLM_EVT_BIAS 2'h1
`define PLM_EVT_DISC 2'h2
`define PLM_EVT_CONN 2'h3

`endif

/* plm_sync2.v */
`timescale 1ns/100ps
// two-flop synchroniser for pin-level inputs
module plm_sync2 #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // async level in, synced level out
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_ff; // first stage, read only by second
  reg [WIDTH-1:0] sync_ff; // second stage

  // plain double flop, no logic between stages
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // plm_sync2

/* plm_power_manager.v */
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "plm_consts.vh"

// Operation
// - D2/D3 with inactive port enters low power
// - low power stops clocks, keeps detect references
// - deepest sleep only disconnected or disabled-without-interrupt
// - writing link power request wakes device
// - qualifying port events also wake device
// - link clock running within 2 ms
// - second-pair bias means active remote connection
// - supply 49.152 MHz link clock to link
module plm_power_manager #(
  parameter WAKE_MAX_CYC = `PLM_WAKE_MAX_CYC, // longest wake time in cycles
  parameter CNT_W = 18 // wake counter width
) (
  // clock, reset, enable
  input wire I_CLK,
  input wire I_RST,
  input wire I_CE,
  // axi4-lite write address and data
  input wire [11:0] I_AWADDR,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output reg O_WREADY,
  // axi4-lite write response
  output reg [1:0] O_BRESP,
  output reg O_BVALID,
  input wire I_BREADY,
  // axi4-lite read
  input wire [11:0] I_ARADDR,
  input wire I_ARVALID,
  output reg O_ARREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg O_RVALID,
  input wire I_RREADY,
  // port condition pins (asynchronous)
  input wire I_PORT_CONNECTED,
  input wire I_PORT_DISABLED,
  input wire I_PORT_SUSPENDED,
  input wire I_CABLE_BIAS_SENSE,
  input wire I_PLL_LOCK,
  // analog / clock controls
  output reg O_CLK_GEN_EN,
  output reg O_REF_EN,
  output reg O_DETECT_REF_EN,
  output reg O_ULP_SLEEP,
  output reg O_LINK_CLK_EN,
  output reg O_PHY_ACTIVE,
  // event notification to link
  output reg O_PORT_EVENT,
  output reg [1:0] O_PORT_EVENT_CODE
);
  // state codes
  localparam ST_ACTIVE = 2'h0;
  localparam ST_LOWPWR = 2'h1;
  localparam ST_WAKING = 2'h2;
  localparam ST_SETTLE = 2'h3;
  localparam integer WAKE_LAST_I = WAKE_MAX_CYC - 1; // full-width deadline
  localparam integer SETTLE_LAST_I = `PLM_SETTLE_CYC - 1;
  // counter-width copies, cut on purpose
  localparam [CNT_W-1:0] WAKE_LAST = WAKE_LAST_I[CNT_W-1:0];
  localparam [CNT_W-1:0] SETTLE_LAST = SETTLE_LAST_I[CNT_W-1:0];

  // byte-enable to bit mask, used by the set/clear pair; power control checks only strobe bit 0
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  wire [4:0] pins_s; // synchronised pins
  wire conn_s = pins_s[0];
  wire dis_s = pins_s[1];
  wire susp_s = pins_s[2];
  wire bias_s = pins_s[3];
  wire lock_s = pins_s[4];

  plm_sync2 #(.WIDTH(5)) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_async({I_PLL_LOCK, I_CABLE_BIAS_SENSE, I_PORT_SUSPENDED, I_PORT_DISABLED,
      I_PORT_CONNECTED}),
    .o_sync(pins_s)
  );

  reg [31:0] hcc_ff; // host controller control contents
  reg [2:0] ctrl_ff; // dstate and port interrupt enable
  reg [1:0] state_ff; // power state machine
  reg [CNT_W-1:0] cnt_ff; // wake / settle counter
  reg conn_d_ff; // previous synced connect
  reg bias_d_ff; // previous synced bias
  reg [1:0] evt_ff; // pending wake event
  reg aw_hold_ff; // write address captured
  reg w_hold_ff; // write data captured
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire link_power_request = hcc_ff[`PLM_HCC_LPS_BIT];
  wire [1:0] dstate = ctrl_ff[1:0];
  wire port_ie = ctrl_ff[`PLM_CTRL_PORT_IE_BIT];
  // remote bias counts as a live connection
  wire linked = conn_s | bias_s;
  wire port_idle = !linked | dis_s | susp_s;
  wire low_dstate = (dstate >= `PLM_DSTATE_D2);
  // deepest sleep: nothing attached, or disabled with interrupts masked
  wire ulp = !linked | (dis_s & !port_ie);

  // port events that need the node awake
  wire ev_bias = susp_s & bias_s & !bias_d_ff;
  wire ev_disc = susp_s & !conn_s & conn_d_ff;
  wire ev_conn = !dis_s & conn_s & !conn_d_ff;
  reg [1:0] ev_code;
  always @* begin
    ev_code = `PLM_EVT_NONE;
    if (ev_bias) begin
      ev_code = `PLM_EVT_BIAS;
    end else if (ev_disc) begin
      ev_code = `PLM_EVT_DISC;
    end else if (ev_conn) begin
      ev_code = `PLM_EVT_CONN;
    end
  end

  // axi write path: address and data may come in either order
  wire do_write = aw_hold_ff & w_hold_ff & !O_BVALID;
  wire [31:0] wm = strb_mask(wstrb_ff);
  wire wr_set = do_write & (awaddr_ff == `PLM_ADDR_HCC_SET);
  wire wr_clr = do_write & (awaddr_ff == `PLM_ADDR_HCC_CLR);
  wire wr_ctrl = do_write & (awaddr_ff == `PLM_ADDR_PWR_CTRL);

  // write channel handshakes and response
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `PLM_RESP_OKAY;
    end else if (I_CE) begin
      O_AWREADY <= !aw_hold_ff & !O_AWREADY & I_AWVALID;
      O_WREADY <= !w_hold_ff & !O_WREADY & I_WVALID;
      if (O_AWREADY & I_AWVALID) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= I_AWADDR;
      end
      if (O_WREADY & I_WVALID) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= I_WDATA;
        wstrb_ff <= I_WSTRB;
      end
      if (do_write) begin
        // unmapped address answers slverr and writes nothing
        O_BVALID <= 1'b1;
        O_BRESP <= (wr_set | wr_clr | wr_ctrl) ? `PLM_RESP_OKAY : `PLM_RESP_SLVERR;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end else if (O_BVALID & I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // registers: set/clear pair and power control
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      hcc_ff <= `PLM_HCC_RST;
      ctrl_ff <= `PLM_CTRL_RST;
    end else if (I_CE) begin
      if (wr_set) begin
        hcc_ff <= hcc_ff | (wdata_ff & wm);
      end else if (wr_clr) begin
        hcc_ff <= hcc_ff & ~(wdata_ff & wm);
      end
      if (wr_ctrl & wstrb_ff[0]) begin
        ctrl_ff <= wdata_ff[2:0];
      end
    end
  end

  // read channel, one cycle latency
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0000_0000;
      O_RRESP <= `PLM_RESP_OKAY;
    end else if (I_CE) begin
      O_ARREADY <= !O_RVALID & !O_ARREADY & I_ARVALID;
      if (O_ARREADY & I_ARVALID) begin
        O_RVALID <= 1'b1;
        O_RRESP <= `PLM_RESP_OKAY;
        case (I_ARADDR)
          `PLM_ADDR_HCC_SET, `PLM_ADDR_HCC_CLR: begin
            O_RDATA <= hcc_ff;
          end
          `PLM_ADDR_PWR_CTRL: begin
            O_RDATA <= {29'h0000_0000, ctrl_ff};
          end
          `PLM_ADDR_STATUS: begin
            // live state, clock, sleep depth, pending event
            O_RDATA <= {24'h00_0000, evt_ff, O_ULP_SLEEP, O_LINK_CLK_EN, state_ff,
              lock_s, linked};
          end
          default: begin
            O_RDATA <= 32'h0000_0000;
            O_RRESP <= `PLM_RESP_SLVERR;
          end
        endcase
      end else if (O_RVALID & I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // power state machine
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_ff <= ST_ACTIVE;
      cnt_ff <= {CNT_W{1'b0}};
      evt_ff <= `PLM_EVT_NONE;
      conn_d_ff <= 1'b0;
      bias_d_ff <= 1'b0;
      O_PORT_EVENT <= 1'b0;
      O_PORT_EVENT_CODE <= `PLM_EVT_NONE;
    end else if (I_CE) begin
      conn_d_ff <= conn_s;
      bias_d_ff <= bias_s;
      O_PORT_EVENT <= 1'b0;
      case (state_ff)
        ST_ACTIVE: begin
          // stay up while software still requests link power
          if (low_dstate & port_idle & !link_power_request) begin
            state_ff <= ST_LOWPWR;
          end
        end
        ST_LOWPWR: begin
          cnt_ff <= {CNT_W{1'b0}};
          if (ev_code != `PLM_EVT_NONE) begin
            evt_ff <= ev_code;
            state_ff <= ST_WAKING;
          end else if (link_power_request) begin
            state_ff <= ST_WAKING;
          end
        end
        ST_WAKING: begin
          // pll lock, or the deadline less the settle window, ends the wait
          cnt_ff <= cnt_ff + 1'b1;
          if (lock_s) begin
            state_ff <= ST_SETTLE;
          end else if (cnt_ff >= WAKE_LAST - SETTLE_LAST - 1'b1) begin
            state_ff <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // settle window keeps total wake under the deadline
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= WAKE_LAST) begin
            state_ff <= ST_ACTIVE;
          end else if (lock_s & (cnt_ff >= SETTLE_LAST)) begin
            state_ff <= ST_ACTIVE;
          end
          if (cnt_ff >= SETTLE_LAST) begin
            cnt_ff <= WAKE_LAST;
          end
        end
        default: begin
          state_ff <= ST_ACTIVE;
        end
      endcase
      // event goes out only in active, on the same edge the link clock is enabled
      if (state_ff == ST_ACTIVE && evt_ff != `PLM_EVT_NONE) begin
        O_PORT_EVENT <= 1'b1;
        O_PORT_EVENT_CODE <= evt_ff;
        evt_ff <= `PLM_EVT_NONE;
      end
    end
  end

  // analog and clock enables follow the state
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CLK_GEN_EN <= 1'b1;
      O_REF_EN <= 1'b1;
      O_DETECT_REF_EN <= 1'b1;
      O_ULP_SLEEP <= 1'b0;
      O_LINK_CLK_EN <= 1'b1;
      O_PHY_ACTIVE <= 1'b1;
    end else if (I_CE) begin
      // generators off only in low power
      O_CLK_GEN_EN <= (state_ff != ST_LOWPWR);
      // bias-sense reference stays on unless in deepest sleep
      O_REF_EN <= (state_ff != ST_LOWPWR) | !ulp;
      // connect detection is never switched off
      O_DETECT_REF_EN <= 1'b1;
      O_ULP_SLEEP <= (state_ff == ST_LOWPWR) & ulp;
      // 49.152 MHz gated to the link only when up
      O_LINK_CLK_EN <= (state_ff == ST_ACTIVE);
      O_PHY_ACTIVE <= (state_ff == ST_ACTIVE);
    end
  end
endmodule // plm_power_manager

/* plm_power_manager_properties.sv */
`timescale 1ns/100ps
// watches power outputs and axi answers of the manager
module plm_power_manager_properties #(
  parameter int WAKE_MAX_CYC = 1400
) (
  input wire I_CLK,
  input wire I_RST,
  input wire I_CE,
  input wire I_BREADY,
  input wire I_RREADY,
  input wire O_BVALID,
  input wire [1:0] O_BRESP,
  input wire O_RVALID,
  input wire [31:0] O_RDATA,
  input wire O_CLK_GEN_EN,
  input wire O_REF_EN,
  input wire O_DETECT_REF_EN,
  input wire O_ULP_SLEEP,
  input wire O_LINK_CLK_EN,
  input wire O_PHY_ACTIVE,
  input wire O_PORT_EVENT,
  input wire [1:0] O_PORT_EVENT_CODE
);
  // slack for sync and output flops
  localparam int WAKE_LIM = WAKE_MAX_CYC + 4;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_restored;
    O_LINK_CLK_EN && O_PHY_ACTIVE;
  endsequence
  sequence s_asleep;
    !O_LINK_CLK_EN && !O_PHY_ACTIVE;
  endsequence
  // cycles with generators up but link clock still gated; frozen cycles not counted
  int wake_cnt;
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wake_cnt <= 0;
    end else if (O_LINK_CLK_EN && O_PHY_ACTIVE) begin
      wake_cnt <= 0;
    end else if (I_CE && O_CLK_GEN_EN) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  property p_wake_bound;
    wake_cnt <= WAKE_LIM;
  endproperty
  a_wake_bound: assert property (p_wake_bound) else $error("link clock late");
  property p_gen_off;
    !O_CLK_GEN_EN |-> s_asleep;
  endproperty
  a_gen_off: assert property (p_gen_off) else $error("link clock without gen");
  property p_detect;
    O_DETECT_REF_EN;
  endproperty
  a_detect: assert property (p_detect) else $error("detect ref off");
  property p_ulp;
    O_ULP_SLEEP |-> !O_REF_EN && !O_CLK_GEN_EN;
  endproperty
  a_ulp: assert property (p_ulp) else $error("deep sleep with refs on");
  property p_ref;
    !O_REF_EN |-> O_ULP_SLEEP;
  endproperty
  a_ref: assert property (p_ref) else $error("refs off outside deep sleep");
  property p_evt;
    O_PORT_EVENT |-> s_restored and O_PORT_EVENT_CODE != 2'h0;
  endproperty
  a_evt: assert property (p_evt) else $error("event before clock");
  property p_evt_pulse;
    O_PORT_EVENT |=> !O_PORT_EVENT;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event not a pulse");
  property p_bhold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule // plm_power_manager_properties

/* plm_port_model.sv */
`timescale 1ns/100ps
// pll stand-in: lock drops with the generators, returns after a delay
module plm_port_model (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // generator enable in, slow lock select
  input wire i_clk_gen_en,
  input wire i_slow,
  output reg o_pll_lock
);
  reg [7:0] cnt_ff; // cycles since generators started
  // slow lock pushes the wake towards its deadline
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 8'h00;
      o_pll_lock <= 1'h1;
    end else if (!i_clk_gen_en) begin
      cnt_ff <= 8'h00;
      o_pll_lock <= 1'h0;
    end else begin
      if (cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
      o_pll_lock <= (cnt_ff >= (i_slow ? 8'hc8 : 8'h10));
    end
  end
endmodule // plm_port_model

/* plm_power_manager_test.sv */
`timescale 1ns/100ps
`include "plm_consts.vh"
module plm_power_manager_test;
  localparam int WAKE_MAX_CYC = 1400; // short deadline, settle still fits
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic conn = 1'h0, dis = 1'h0, susp = 1'h0, bias = 1'h0, slow = 1'h0;
  logic [1:0] rsp;
  wire awready, wready, bvalid, arready, rvalid, lock, gen_en, ref_en, det_en;
  wire ulp, link_en, phy_act, evt;
  wire [1:0] bresp, rresp, evt_code;
  wire [31:0] rdata;
  int n_errors = 0, n_compared = 0, cyc = 0;
  plm_power_manager #(.WAKE_MAX_CYC(WAKE_MAX_CYC)) plm_power_manager_inst (
    .I_CLK(clk), .I_RST(rst), .I_CE(1'h1), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
    .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_PORT_CONNECTED(conn),
    .I_PORT_DISABLED(dis), .I_PORT_SUSPENDED(susp), .I_CABLE_BIAS_SENSE(bias),
    .I_PLL_LOCK(lock), .O_CLK_GEN_EN(gen_en), .O_REF_EN(ref_en),
    .O_DETECT_REF_EN(det_en), .O_ULP_SLEEP(ulp), .O_LINK_CLK_EN(link_en),
    .O_PHY_ACTIVE(phy_act), .O_PORT_EVENT(evt), .O_PORT_EVENT_CODE(evt_code));
  plm_port_model plm_port_model_inst (.i_clk(clk), .i_rst(rst), .i_clk_gen_en(gen_en),
    .i_slow(slow), .o_pll_lock(lock));
  always #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // axi write, each channel released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awready && awvalid) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready && wvalid) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge clk);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  // host state write, then low power with the expected sleep depth
  task automatic sleep(input logic [2:0] ctrl, input logic exp_ulp);
    int k;
    wr(`PLM_ADDR_PWR_CTRL, {29'h0, ctrl});
    repeat (8) @(negedge clk);
    for (k = 0; k < 40 && gen_en !== 1'h0; k++) @(negedge clk);
    chk(gen_en, 0);
    chk(ulp, exp_ulp);
    chk(ref_en, !exp_ulp);
  endtask
  task automatic wake_evt(input logic [1:0] code);
    int k;
    for (k = 0; k < 2000 && evt !== 1'h1; k++) @(negedge clk);
    chk(evt, 1);
    chk(evt_code, code);
    chk(link_en, 1);
  endtask
  task automatic wrap_up;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    int k;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk({gen_en, ulp, link_en, det_en}, 4'hb);
    rd_reg(`PLM_ADDR_HCC_SET);
    chk(rd, `PLM_HCC_RST);
    rd_reg(12'h100);
    chk(rsp, `PLM_RESP_SLVERR);
    wr(12'h100, 32'hffff_ffff);
    chk(rsp, `PLM_RESP_SLVERR);
    // host state D1 keeps the phy up
    wr(`PLM_ADDR_PWR_CTRL, 32'h0000_0001);
    repeat (20) @(negedge clk);
    chk(gen_en, 1);
    sleep(3'h2, 1'h1);
    @(posedge clk) slow <= 1'h1;
    wr(`PLM_ADDR_HCC_SET, 32'h0008_0000);
    for (k = 0; k < WAKE_MAX_CYC + 8 && link_en !== 1'h1; k++) @(negedge clk);
    chk({link_en, phy_act}, 2'h3);
    rd_reg(`PLM_ADDR_HCC_SET);
    chk(rd, 32'h0008_0000);
    @(posedge clk) slow <= 1'h0;
    wr(`PLM_ADDR_HCC_CLR, 32'h0008_0000);
    sleep(3'h2, 1'h1);
    @(posedge clk) conn <= 1'h1;
    wake_evt(`PLM_EVT_CONN);
    @(posedge clk) susp <= 1'h1;
    sleep(3'h7, 1'h0);
    @(posedge clk) bias <= 1'h1;
    wake_evt(`PLM_EVT_BIAS);
    @(posedge clk) bias <= 1'h0;
    sleep(3'h7, 1'h0);
    @(posedge clk) conn <= 1'h0;
    wake_evt(`PLM_EVT_DISC);
    @(posedge clk) {conn, susp, dis} <= 3'h5;
    sleep(3'h7, 1'h0);
    sleep(3'h3, 1'h1);
    rd_reg(`PLM_ADDR_PWR_CTRL);
    chk(rd, 32'h0000_0003);
    rd_reg(`PLM_ADDR_STATUS);
    chk(rd, 32'h0000_0025);
    wrap_up;
  end
endmodule // plm_power_manager_test
bind plm_power_manager plm_power_manager_properties #(.WAKE_MAX_CYC(WAKE_MAX_CYC)) plm_props_inst (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CE(I_CE), .I_BREADY(I_BREADY), .I_RREADY(I_RREADY),
  .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
  .O_CLK_GEN_EN(O_CLK_GEN_EN), .O_REF_EN(O_REF_EN), .O_DETECT_REF_EN(O_DETECT_REF_EN),
  .O_ULP_SLEEP(O_ULP_SLEEP), .O_LINK_CLK_EN(O_LINK_CLK_EN), .O_PHY_ACTIVE(O_PHY_ACTIVE),
  .O_PORT_EVENT(O_PORT_EVENT), .O_PORT_EVENT_CODE(O_PORT_EVENT_CODE));
